// ==== common/t1cw_map.svh ====
`ifndef T1CW_MAP_SVH
`define T1CW_MAP_SVH

// Byte offsets on the register bus
`define T1CW_OFF_COUNT       8'h00
`define T1CW_OFF_TOP         8'h04
`define T1CW_OFF_CMP_A       8'h08
`define T1CW_OFF_CMP_B       8'h0C
`define T1CW_OFF_CMP_D       8'h10
`define T1CW_OFF_CTRL_X      8'h14
`define T1CW_OFF_PIN_DIR     8'h18
`define T1CW_OFF_PORT_DATA   8'h1C
`define T1CW_OFF_CTRL_A      8'h30
`define T1CW_OFF_FLAGS       8'h38

// Control A fields
`define T1CW_CA_MODE_A_HI    7
`define T1CW_CA_MODE_A_LO    6
`define T1CW_CA_MODE_B_HI    5
`define T1CW_CA_MODE_B_LO    4
`define T1CW_CA_FORCE_A      3
`define T1CW_CA_FORCE_B      2
`define T1CW_CA_PWM_A        1
`define T1CW_CA_PWM_B        0

// Flag register fields
`define T1CW_FL_CMP_D        7
`define T1CW_FL_CMP_A        6
`define T1CW_FL_CMP_B        5
`define T1CW_FL_OVF          2

// Extra control fields
`define T1CW_CX_WGM_HI       1
`define T1CW_CX_WGM_LO       0
`define T1CW_CX_MODE_D_HI    3
`define T1CW_CX_MODE_D_LO    2
`define T1CW_CX_OE4          4
`define T1CW_CX_OE5          5

// Pin indices
`define T1CW_PIN_A           0
`define T1CW_PIN_A_N         1
`define T1CW_PIN_B           2
`define T1CW_PIN_B_N         3
`define T1CW_PIN_B4          4
`define T1CW_PIN_B5          5
`define T1CW_NUM_PINS        6

// Encodings
`define T1CW_COM_OFF         2'b00
`define T1CW_COM_TOGGLE      2'b01
`define T1CW_COM_CLEAR       2'b10
`define T1CW_COM_SET         2'b11
`define T1CW_WGM_FAST        2'b00
`define T1CW_WGM_SIX         2'b01
`define T1CW_HSIZE_WORD      3'b010

// Reset values
`define T1CW_RST_BYTE        8'h00
`define T1CW_RST_WORD        32'h00000000

`endif

// ==== common/t1cw_pkg.sv ====
package t1cw_pkg;
   // Bus slave phase tracking
   typedef enum logic [1:0] {t1cw_bus_idle, t1cw_bus_write, t1cw_bus_read} t1cw_bus_t;
   typedef logic [7:0] t1cw_byte_t;
   typedef logic [1:0] t1cw_mode_t;
endpackage

// ==== common/t1cw_chan_if.sv ====
`timescale 1ns/10ps
// One compare channel: count and settings in, waveform and match out
interface t1cw_chan_if #(parameter int COUNT_W = 8);
   logic                     tick;
   logic                     force_match;
   logic                     pwm;
   t1cw_pkg::t1cw_mode_t     mode;
   logic [COUNT_W-1:0]       count;
   logic [COUNT_W-1:0]       compare;
   logic                     wave;
   logic                     match;
   modport unit (input tick, force_match, pwm, mode, count, compare, output wave, match);
   modport ctrl (output tick, force_match, pwm, mode, count, compare, input wave, match);
endinterface

// ==== hdl/t1cw_chan.sv ====
`timescale 1ns/10ps
`include "t1cw_map.svh"
module t1cw_chan (
   input wire logic     hclk,
   input wire logic     hresetn,
   t1cw_chan_if.unit    ch
);
   logic wave;
   logic next_wave;
   logic hit;
   logic bottom;

   // Match is only meaningful on a tick; a force acts as a match without a flag
   assign ch.match = ch.tick & (ch.count == ch.compare);
   assign ch.wave  = wave;

   ////////////////////////////////////////////////////////////////////////////
   // Waveform next state
   always_comb begin
      hit       = ch.match | ch.force_match;
      bottom    = ch.tick & (ch.count == '0);
      next_wave = wave;
      if (ch.pwm) begin
         // Bottom first so a match at zero still wins
         if (bottom && ch.mode != `T1CW_COM_OFF) begin
            next_wave = (ch.mode != `T1CW_COM_SET);
         end
         if (hit && ch.mode != `T1CW_COM_OFF) begin
            next_wave = (ch.mode == `T1CW_COM_SET);
         end
      end else if (hit) begin
         unique case (ch.mode)
            `T1CW_COM_OFF:    next_wave = wave;
            `T1CW_COM_TOGGLE: next_wave = ~wave;
            `T1CW_COM_CLEAR:  next_wave = 1'b0;
            `T1CW_COM_SET:    next_wave = 1'b1;
         endcase
      end
   end

   // Waveform register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wave <= 1'b0;
      end else begin
         wave <= next_wave;
      end
   end
endmodule // t1cw_chan

// ==== hdl/t1cw_top.sv ====
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "t1cw_map.svh"
// Notes on behaviour
// - Normal mode counts to top, then wraps zero
// - Overflow flag set when count reaches zero
// - Software may write the count any time
// - Non-PWM mode one toggles waveform on each match
// - Pin driven only when direction selects output
// - Toggle period is two times top plus one
// - Nonzero channel A mode overrides pin function
// - Complement pin only in PWM, mode 01
// - Fast PWM: enable set and generation mode 00 or 01
// - Fast PWM counts zero to top, restarts
// - Non-inverting: clear on match, set at zero
// - Inverting: set on match, clear at zero
// - Six-output mode gates A waveform per pin
// - Counter advances only on timer tick enable
// - Control A field layout, resets to zero
// - Flag register layout, resets, bit 0 read-only
// - Non-PWM modes: port, toggle, clear, set
// - PWM mode 11 sets on match, clears zero
module t1cw_top #(
   parameter int COUNT_W = 8
) (
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output      logic [31:0]              hrdata,
   output      logic                     hreadyout,
   output      logic                     hresp,
   input  wire logic                     timer_tick_enable,
   input  wire logic [3:0]               flag_ack,
   output      logic [3:0]               timer_flags,
   output      logic [5:0]               pin_out,
   output      logic [5:0]               pin_oe
);
   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Fast single-slope PWM (plain or six-output) is selected per channel
   function automatic logic is_pwm(input logic en, input t1cw_pkg::t1cw_mode_t wgm);
      is_pwm = en && (wgm == `T1CW_WGM_FAST || wgm == `T1CW_WGM_SIX);
   endfunction

   // Overridden pins take the waveform, others the port data
   function automatic logic drive(input logic ovr, input logic wave, input logic port);
      drive = ovr ? wave : port;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State

   t1cw_pkg::t1cw_bus_t      bus_state;
   t1cw_pkg::t1cw_bus_t      next_bus_state;
   t1cw_pkg::t1cw_byte_t     addr_q;
   t1cw_pkg::t1cw_byte_t     next_addr_q;
   logic [31:0]              next_hrdata;
   logic                     next_hreadyout;

   t1cw_pkg::t1cw_byte_t     ctrl_a;
   t1cw_pkg::t1cw_byte_t     next_ctrl_a;
   logic [3:0]               next_flags;
   logic [COUNT_W-1:0]       count;
   logic [COUNT_W-1:0]       next_count;
   logic [COUNT_W-1:0]       top;
   logic [COUNT_W-1:0]       next_top;
   logic [COUNT_W-1:0]       cmp_a;
   logic [COUNT_W-1:0]       next_cmp_a;
   logic [COUNT_W-1:0]       cmp_b;
   logic [COUNT_W-1:0]       next_cmp_b;
   logic [COUNT_W-1:0]       cmp_d;
   logic [COUNT_W-1:0]       next_cmp_d;
   logic [5:0]               ctrl_x;
   logic [5:0]               next_ctrl_x;
   logic [5:0]               pin_dir;
   logic [5:0]               next_pin_dir;
   logic [5:0]               port_data;
   logic [5:0]               next_port_data;
   logic                     force_a;
   logic                     next_force_a;
   logic                     force_b;
   logic                     next_force_b;
   logic [5:0]               next_pin_out;

   // Decoded controls and write strobes
   logic                     accept;
   logic                     wr_en;
   t1cw_pkg::t1cw_byte_t     wdata;
   t1cw_pkg::t1cw_mode_t     mode_a;
   t1cw_pkg::t1cw_mode_t     mode_b;
   t1cw_pkg::t1cw_mode_t     mode_d;
   t1cw_pkg::t1cw_mode_t     wgm;
   logic                     pwm_a;
   logic                     pwm_b;
   logic                     six;
   logic                     wrap;
   logic [3:0]               flag_set;
   logic [3:0]               flag_clr;
   logic [5:0]               ovr;
   logic [5:0]               val;

   t1cw_chan_if #(.COUNT_W(COUNT_W)) ch_a ();
   t1cw_chan_if #(.COUNT_W(COUNT_W)) ch_b ();
   t1cw_chan_if #(.COUNT_W(COUNT_W)) ch_d ();

   ////////////////////////////////////////////////////////////////////////////
   // Field decode
   assign mode_a = ctrl_a[`T1CW_CA_MODE_A_HI:`T1CW_CA_MODE_A_LO];
   assign mode_b = ctrl_a[`T1CW_CA_MODE_B_HI:`T1CW_CA_MODE_B_LO];
   assign mode_d = ctrl_x[`T1CW_CX_MODE_D_HI:`T1CW_CX_MODE_D_LO];
   assign wgm    = ctrl_x[`T1CW_CX_WGM_HI:`T1CW_CX_WGM_LO];
   assign pwm_a  = is_pwm(ctrl_a[`T1CW_CA_PWM_A], wgm);
   assign pwm_b  = is_pwm(ctrl_a[`T1CW_CA_PWM_B], wgm);
   assign six    = ctrl_a[`T1CW_CA_PWM_A] && (wgm == `T1CW_WGM_SIX);

   // Channel hookup; all three share the one counter
   assign ch_a.tick        = timer_tick_enable;
   assign ch_a.force_match = force_a;
   assign ch_a.pwm         = pwm_a;
   assign ch_a.mode        = mode_a;
   assign ch_a.count       = count;
   assign ch_a.compare     = cmp_a;
   assign ch_b.tick        = timer_tick_enable;
   assign ch_b.force_match = force_b;
   assign ch_b.pwm         = pwm_b;
   assign ch_b.mode        = mode_b;
   assign ch_b.count       = count;
   assign ch_b.compare     = cmp_b;
   assign ch_d.tick        = timer_tick_enable;
   assign ch_d.force_match = 1'b0;
   assign ch_d.pwm         = six;
   assign ch_d.mode        = mode_d;
   assign ch_d.count       = count;
   assign ch_d.compare     = cmp_d;

   t1cw_chan u_chan_a (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ch      (ch_a.unit)
   );
   t1cw_chan u_chan_b (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ch      (ch_b.unit)
   );
   t1cw_chan u_chan_d (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ch      (ch_d.unit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: writes take no wait state, reads take one
   always_comb begin
      accept         = hsel && hready && htrans[1] && (hsize == `T1CW_HSIZE_WORD);
      wr_en          = (bus_state == t1cw_pkg::t1cw_bus_write);
      wdata          = hwdata[7:0];
      next_bus_state = t1cw_pkg::t1cw_bus_idle;
      next_addr_q    = addr_q;
      next_hreadyout = 1'b1;
      next_hrdata    = hrdata;
      if (bus_state == t1cw_pkg::t1cw_bus_read) begin
         // The wait state lets a write just before land first
         unique case (addr_q)
            `T1CW_OFF_COUNT:     next_hrdata = 32'(count);
            `T1CW_OFF_TOP:       next_hrdata = 32'(top);
            `T1CW_OFF_CMP_A:     next_hrdata = 32'(cmp_a);
            `T1CW_OFF_CMP_B:     next_hrdata = 32'(cmp_b);
            `T1CW_OFF_CMP_D:     next_hrdata = 32'(cmp_d);
            `T1CW_OFF_CTRL_X:    next_hrdata = 32'(ctrl_x);
            `T1CW_OFF_PIN_DIR:   next_hrdata = 32'(pin_dir);
            `T1CW_OFF_PORT_DATA: next_hrdata = 32'(port_data);
            `T1CW_OFF_CTRL_A:    next_hrdata = 32'(ctrl_a);
            `T1CW_OFF_FLAGS:     next_hrdata = 32'({timer_flags[3:1], 2'b00,
                                                    timer_flags[0], 2'b00});
            default:             next_hrdata = `T1CW_RST_WORD;
         endcase
      end
      if (accept) begin
         next_addr_q    = haddr[7:0];
         next_bus_state = hwrite ? t1cw_pkg::t1cw_bus_write : t1cw_pkg::t1cw_bus_read;
         next_hreadyout = hwrite;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers, counter and flags
   always_comb begin
      next_ctrl_a    = ctrl_a;
      next_top       = top;
      next_cmp_a     = cmp_a;
      next_cmp_b     = cmp_b;
      next_cmp_d     = cmp_d;
      next_ctrl_x    = ctrl_x;
      next_pin_dir   = pin_dir;
      next_port_data = port_data;
      next_force_a   = 1'b0;
      next_force_b   = 1'b0;
      flag_clr       = flag_ack;
      // Same wrap in normal and fast PWM: single slope up to top
      wrap           = timer_tick_enable && (count == top);
      next_count     = count;
      if (timer_tick_enable) begin
         next_count = wrap ? '0 : COUNT_W'(count + 1'b1);
      end
      if (wr_en) begin
         unique case (addr_q)
            `T1CW_OFF_COUNT:     next_count     = hwdata[COUNT_W-1:0];
            `T1CW_OFF_TOP:       next_top       = hwdata[COUNT_W-1:0];
            `T1CW_OFF_CMP_A:     next_cmp_a     = hwdata[COUNT_W-1:0];
            `T1CW_OFF_CMP_B:     next_cmp_b     = hwdata[COUNT_W-1:0];
            `T1CW_OFF_CMP_D:     next_cmp_d     = hwdata[COUNT_W-1:0];
            `T1CW_OFF_CTRL_X:    next_ctrl_x    = wdata[5:0];
            `T1CW_OFF_PIN_DIR:   next_pin_dir   = wdata[5:0];
            `T1CW_OFF_PORT_DATA: next_port_data = wdata[5:0];
            `T1CW_OFF_CTRL_A: begin
               // Strobe bits are never stored, so they read back zero
               next_ctrl_a  = {wdata[7:4], 2'b00, wdata[1:0]};
               next_force_a = wdata[`T1CW_CA_FORCE_A];
               next_force_b = wdata[`T1CW_CA_FORCE_B];
            end
            `T1CW_OFF_FLAGS: begin
               flag_clr = flag_ack | {wdata[`T1CW_FL_CMP_D], wdata[`T1CW_FL_CMP_A],
                                      wdata[`T1CW_FL_CMP_B], wdata[`T1CW_FL_OVF]};
            end
            default: begin
            end
         endcase
      end
      // A software count write suppresses the wrap it replaces
      flag_set   = {ch_d.match, ch_a.match, ch_b.match,
                    wrap && !(wr_en && addr_q == `T1CW_OFF_COUNT)};
      // Set beats clear so an event in the clearing cycle survives
      next_flags = (timer_flags & ~flag_clr) | flag_set;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin override table
   always_comb begin
      ovr = '0;
      val = '0;
      ovr[`T1CW_PIN_A]   = (mode_a != `T1CW_COM_OFF);
      val[`T1CW_PIN_A]   = ch_a.wave;
      ovr[`T1CW_PIN_A_N] = pwm_a && (mode_a == `T1CW_COM_TOGGLE);
      val[`T1CW_PIN_A_N] = ~ch_a.wave;
      ovr[`T1CW_PIN_B]   = (mode_b != `T1CW_COM_OFF);
      val[`T1CW_PIN_B]   = ch_b.wave;
      ovr[`T1CW_PIN_B_N] = pwm_b && (mode_b == `T1CW_COM_TOGGLE);
      val[`T1CW_PIN_B_N] = ~ch_b.wave;
      if (six && mode_d != `T1CW_COM_OFF) begin
         // Both D pins follow channel A, each gated by its own enable
         ovr[`T1CW_PIN_B4] = 1'b1;
         val[`T1CW_PIN_B4] = ch_a.wave & ctrl_x[`T1CW_CX_OE4];
         ovr[`T1CW_PIN_B5] = 1'b1;
         val[`T1CW_PIN_B5] = ch_a.wave & ctrl_x[`T1CW_CX_OE5];
      end else begin
         ovr[`T1CW_PIN_B5] = (mode_d != `T1CW_COM_OFF);
         val[`T1CW_PIN_B5] = ch_d.wave;
      end
      for (int i = 0; i < `T1CW_NUM_PINS; i++) begin
         next_pin_out[i] = drive(ovr[i], val[i], port_data[i]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flip-flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state   <= t1cw_pkg::t1cw_bus_idle;
         addr_q      <= `T1CW_RST_BYTE;
         hrdata      <= `T1CW_RST_WORD;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         ctrl_a      <= `T1CW_RST_BYTE;
         timer_flags <= '0;
         count       <= '0;
         top         <= '1;
         cmp_a       <= '0;
         cmp_b       <= '0;
         cmp_d       <= '0;
         ctrl_x      <= '0;
         pin_dir     <= '0;
         port_data   <= '0;
         force_a     <= 1'b0;
         force_b     <= 1'b0;
         pin_out     <= '0;
         pin_oe      <= '0;
      end else begin
         bus_state   <= next_bus_state;
         addr_q      <= next_addr_q;
         hrdata      <= next_hrdata;
         hreadyout   <= next_hreadyout;
         hresp       <= 1'b0;                                        // Always OKAY
         ctrl_a      <= next_ctrl_a;
         timer_flags <= next_flags;
         count       <= next_count;
         top         <= next_top;
         cmp_a       <= next_cmp_a;
         cmp_b       <= next_cmp_b;
         cmp_d       <= next_cmp_d;
         ctrl_x      <= next_ctrl_x;
         pin_dir     <= next_pin_dir;
         port_data   <= next_port_data;
         force_a     <= next_force_a;
         force_b     <= next_force_b;
         pin_out     <= next_pin_out;
         pin_oe      <= pin_dir;
      end
   end
endmodule // t1cw_top

// ==== verification/t1cw_top_sva.sv ====
`timescale 1ns/10ps
module t1cw_sva #(
   parameter int COUNT_W = 8
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        timer_tick_enable,
   input wire logic [3:0]  flag_ack,
   input wire logic [3:0]  timer_flags,
   input wire logic [5:0]  pin_out,
   input wire logic [5:0]  pin_oe
);
   logic       rd_dp, next_rd_dp, wr_dp, next_wr_dp;
   logic [7:0] a_adr, next_a_adr;
   logic [5:0] dir, next_dir;
   wire        taken = hsel && hready && htrans[1] && hsize == 3'h2;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of bus phases and of the direction register; only word transfers count
   always_comb begin
      next_rd_dp = (rd_dp && hreadyout) ? 1'b0 : rd_dp;
      next_wr_dp = 1'b0;
      next_a_adr = a_adr;
      next_dir   = (wr_dp && a_adr == 8'h18) ? hwdata[5:0] : dir;
      if (taken) begin
         next_a_adr = haddr[7:0];
         next_rd_dp = !hwrite;
         next_wr_dp = hwrite;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_dp <= 1'b0;
         wr_dp <= 1'b0;
         a_adr <= 8'h00;
         dir   <= 6'h00;
      end else begin
         rd_dp <= next_rd_dp;
         wr_dp <= next_wr_dp;
         a_adr <= next_a_adr;
         dir   <= next_dir;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One wait state per read, so a read right after a write sees the new value
   AST_READ_WAIT:
      assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait");
   // The slave has no error case, so every response must be OKAY
   AST_RESP_OKAY:
      assert property (!hresp) else $error("response not okay");
   AST_OE_DIR:
      assert property (pin_oe == $past(dir)) else $error("pin enable not direction");
   AST_FLAG_ON_TICK:
      assert property (|(timer_flags & ~$past(timer_flags)) |-> $past(timer_tick_enable))
      else $error("flag set without tick");
   AST_OVF_HELD:
      assert property ($fell(timer_flags[0]) |->
         $past(flag_ack[0] || (wr_dp && a_adr == 8'h38 && hwdata[2])))
      else $error("overflow flag cleared by counting");
   AST_ACK_CLEARS:
      assert property (flag_ack[2] && !timer_tick_enable |=> !timer_flags[2])
      else $error("serviced flag stays");
   AST_W1C:
      assert property (wr_dp && a_adr == 8'h38 && hwdata[6] && !timer_tick_enable
         |=> !timer_flags[2]) else $error("write one does not clear");
   AST_CTRL_FORCE_ZERO:
      assert property (rd_dp && hreadyout && a_adr == 8'h30 |->
         hrdata[3:2] == 2'h0 && hrdata[31:8] == 24'h0) else $error("strobe reads one");
   AST_FLAGS_RSVD:
      assert property (rd_dp && hreadyout && a_adr == 8'h38 |->
         hrdata[4:3] == 2'h0 && hrdata[1:0] == 2'h0) else $error("reserved flag bit set");
endmodule // t1cw_sva
bind t1cw_top t1cw_sva #(.COUNT_W(COUNT_W)) u_sva (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .timer_tick_enable(timer_tick_enable), .flag_ack(flag_ack),
   .timer_flags(timer_flags), .pin_out(pin_out), .pin_oe(pin_oe));

// ==== verification/timer1_compare_waveform_tb_top.sv ====
`timescale 1ns/10ps
module timer1_compare_waveform_tb_top;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        tick = 1'b0;
   logic [3:0]  flag_ack = 4'h0;
   logic [31:0] hrdata;
   logic        hreadyout, hresp;
   logic [3:0]  timer_flags;
   logic [5:0]  pin_out, pin_oe;
   logic        rd_wait = 1'b0;
   logic [31:0] exp_q[$];
   logic [31:0] seed = 32'h8022B46D;
   int          bad_count = 0;
   int          comparisons = 0;
   int          ones, chg;

   t1cw_top #(.COUNT_W(8)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .timer_tick_enable(tick), .flag_ack(flag_ack), .timer_flags(timer_flags),
      .pin_out(pin_out), .pin_oe(pin_oe));

   always #25 hclk = ~hclk;
   ////////////////////////////////////////////////////////////////////////////////
   // Helpers: random source, comparison, ending
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic note(input string s);
      $display("test %s finished", s);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Bus master; hready is judged mid-cycle so the edge never races the slave
   // No cycle limit of its own: a slave that never answers is left to the watchdog
   task automatic wait_rdy();
      @(negedge hclk);
      while (hreadyout !== 1'b1) begin
         @(negedge hclk);
      end
      @(posedge hclk);
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      if (!w) begin
         exp_q.push_back(d);
         rd_wait <= 1'b1;
      end
      wait_rdy();
      rd_wait <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, e);
   endtask
   // Read data stands in the second data-phase cycle; oldest note is the match
   always @(negedge hclk) begin
      if (rd_wait && hreadyout === 1'b1)
         check(hrdata, exp_q.pop_front());
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Stimulus helpers for the counter and the pins
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge hclk);
         tick <= 1'b1;
         @(posedge hclk);
         tick <= 1'b0;
      end
   endtask
   task automatic meas(input int i, input int n);
      logic p;
      ones = 0;
      chg = 0;
      @(negedge hclk);
      p = pin_out[i];
      repeat (n) begin
         @(negedge hclk);
         ones += int'(pin_out[i]);
         if (pin_out[i] !== p)
            chg++;
         p = pin_out[i];
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      rd(8'h30, 32'h0);
      rd(8'h38, 32'h0);
      rd(8'h04, 32'hFF);
      rd(8'h40, 32'h0);
      note("reset");
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         wr(8'h08 + 8'(4 * i), seed);
         rd(8'h08 + 8'(4 * i), {24'h0, seed[7:0]});
      end
      wr(8'h30, 32'hFF);
      rd(8'h30, 32'hF3);
      wr(8'h30, 32'h0);
      note("registers");
      wr(8'h08, 32'h8);
      wr(8'h0C, 32'hF0);
      wr(8'h10, 32'hF0);
      wr(8'h04, 32'h9);
      wr(8'h00, 32'h7);
      rd(8'h00, 32'h7);
      ticks(3);
      rd(8'h00, 32'h0);
      rd(8'h38, 32'h44);
      check({28'h0, timer_flags}, 32'h5);
      @(posedge hclk);
      flag_ack <= 4'hF;
      @(posedge hclk);
      flag_ack <= 4'h0;
      rd(8'h38, 32'h0);
      wr(8'h00, 32'h9);
      ticks(1);
      rd(8'h38, 32'h04);
      wr(8'h38, 32'h04);
      rd(8'h38, 32'h0);
      note("counter");
      // Toggle in normal mode: two top-plus-one periods per full cycle
      wr(8'h14, 32'h02);
      wr(8'h04, 32'h3);
      wr(8'h08, 32'h1);
      wr(8'h1C, 32'h0);
      wr(8'h18, 32'h1);
      wr(8'h30, 32'h40);
      tick <= 1'b1;
      repeat (8) @(posedge hclk);
      meas(0, 16);
      check(32'(chg), 32'd4);
      check({26'h0, pin_oe}, 32'h01);
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h0);
      repeat (8) @(posedge hclk);
      meas(0, 16);
      check(32'(chg), 32'd16);
      wr(8'h18, 32'h0);
      repeat (4) @(posedge hclk);
      check({26'h0, pin_oe}, 32'h0);
      note("toggle");
      // Fast PWM, output modes one to three; complement pin only for mode one
      wr(8'h14, 32'h0);
      wr(8'h04, 32'h7);
      wr(8'h08, 32'h2);
      wr(8'h18, 32'h3);
      wr(8'h0C, 32'h5);
      for (int m = 1; m < 4; m++) begin
         wr(8'h30, {24'h0, 2'(m), 2'(m), 4'h3});
         repeat (20) @(posedge hclk);
         meas(0, 32);
         check(32'(ones), m == 3 ? 32'd24 : 32'd8);
         meas(1, 32);
         check(32'(ones), m == 1 ? 32'd24 : 32'd0);
         meas(2, 32);
         check(32'(ones), m == 3 ? 32'd12 : 32'd20);
         meas(3, 32);
         check(32'(ones), m == 1 ? 32'd12 : 32'd0);
      end
      note("fast pwm");
      wr(8'h18, 32'h30);
      wr(8'h30, 32'h82);
      for (int k = 0; k < 2; k++) begin
         wr(8'h14, k == 1 ? 32'h25 : 32'h15);
         repeat (20) @(posedge hclk);
         meas(4, 32);
         check(32'(ones), k == 1 ? 32'd0 : 32'd8);
         meas(5, 32);
         check(32'(ones), k == 1 ? 32'd8 : 32'd0);
      end
      note("six output");
      // Force strobes with the counter halted, so no match can interfere
      wr(8'h14, 32'h02);
      tick <= 1'b0;
      wr(8'h00, 32'h0);
      wr(8'h08, 32'h50);
      wr(8'h18, 32'h1);
      wr(8'h38, 32'hFF);
      wr(8'h30, 32'h88);
      repeat (4) @(posedge hclk);
      check({31'h0, pin_out[0]}, 32'h0);
      wr(8'h30, 32'hC8);
      repeat (4) @(posedge hclk);
      check({31'h0, pin_out[0]}, 32'h1);
      rd(8'h30, 32'hC0);
      rd(8'h38, 32'h0);
      note("force");
      conclude();
   end
   // Whole run needs about a thousand cycles; this bound only catches a hang
   initial begin
      repeat (30000) @(posedge hclk);
      bad_count++;
      conclude();
   end
endmodule // timer1_compare_waveform_tb_top
